//--- verif/uic_properties.sv
`timescale 1ns/100ps
`default_nettype none
module uic_chk #(
  parameter [7:0] IDENT4 = 8'h33 // arbitrary
) (
  input wire MCLK,
  input wire RESET,
  input wire CE,
  input wire [11:0] ADDR,
  input wire WR,
  input wire RD,
  input wire [31:0] RDATA,
  input wire IRQ
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (RESET);
  wire go = RD && CE;
  sequence s_mis; go && ADDR == 12'h040; endsequence
  sequence s_id; go && ADDR == 12'hFD0; endsequence
  a_idle_zero: assert property (CE && !RD |=> RDATA == '0) else $error("idle");
  a_write_quiet: assert property (WR && CE |=> !RDATA) else $error("wr");
  a_mis_rsvd: assert property (s_mis |=> !RDATA[31:11] && !RDATA[3:0]) else $error("rsv");
  a_irq_match: assert property (s_mis |=> IRQ == |RDATA) else $error("irq");
  a_id_byte: assert property (s_id |=> RDATA[7:0] == IDENT4) else $error("id");
  a_id_rsvd: assert property (s_id |=> !RDATA[31:8]) else $error("idhi");
  a_hole_zero: assert property (go && ADDR == 12'h100 |=> !RDATA) else $error("hole");
  a_reset_clean: assert property ($fell(RESET) |-> !IRQ && !RDATA) else $error("rst");
endmodule
`default_nettype wire
bind uic_top uic_chk #(.IDENT4(IDENT4)) u_chk (.MCLK(MCLK), .RESET(RESET), .CE(CE),
  .ADDR(ADDR), .WR(WR), .RD(RD), .RDATA(RDATA), .IRQ(IRQ));

//--- verif/uic_top_test.sv
`timescale 1ns/100ps
`default_nettype none
module uic_top_test;
  logic MCLK = 0, RESET = 1, CE = 1, WR = 0, RD = 0, IRQ;
  logic [11:0] ADDR = '0;
  logic [31:0] WDATA = '0, RDATA;
  logic [6:0] ev = '0;
  int errors = 0, cmp_count = 0;
  uic_top dut (.MCLK(MCLK), .RESET(RESET), .CE(CE), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .OVERRUN_EVT(ev[6]), .BREAK_EVT(ev[5]), .PARITY_EVT(ev[4]), .FRAMING_EVT(ev[3]),
    .RX_TIMEOUT_EVT(ev[2]), .TX_EVT(ev[1]), .RX_EVT(ev[0]), .RDATA(RDATA), .IRQ(IRQ));
  initial forever #50 MCLK = ~MCLK;
  task end_of_test;
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(string n, logic [31:0] e, s);
    cmp_count++;
    if (s !== e) begin
      errors++;
      $display("mismatch %s exp %h got %h", n, e, s);
    end
  endtask
  task wr(logic [11:0] a, logic [31:0] d);
    @(posedge MCLK);
    WR <= 1;
    ADDR <= a;
    WDATA <= d;
    @(posedge MCLK);
    WR <= 0;
  endtask
  task rd(logic [11:0] a, logic [31:0] e);
    @(posedge MCLK);
    RD <= 1;
    ADDR <= a;
    @(posedge MCLK);
    RD <= 0;
    #1 chk("rdata", e, RDATA);
  endtask
  task t_id;
    rd(12'h040, '0);
    wr(12'hFD0, '1);
    rd(12'hFD0, 32'h5A);
    rd(12'h100, '0);
  endtask
  task t_irq;
    wr(12'h048, 32'h7F0);
    ev <= '1;
    // events pass a two-flop synchroniser before setting raw bits
    repeat (5) @(posedge MCLK);
    rd(12'h040, 32'h7F0);
    chk("irq", 1, IRQ);
    wr(12'h040, '0);
    rd(12'h040, 32'h7F0);
    wr(12'h044, 32'h400);
    rd(12'h040, 32'h3F0);
    wr(12'h044, 32'h3F0);
    rd(12'h040, '0);
    chk("irq", 0, IRQ);
  endtask
  task t_mask;
    @(posedge MCLK);
    ev <= '0;
    wr(12'h048, '0);
    repeat (3) @(posedge MCLK);
    ev <= '1;
    repeat (5) @(posedge MCLK);
    rd(12'h03C, 32'h7F0);
    rd(12'h040, '0);
    chk("irq", 0, IRQ);
  endtask
  task t_race;
    wr(12'h044, 32'h7F0);
    ev <= '0;
    repeat (4) @(posedge MCLK);
    ev <= '1;
    // the clear strobe lands on the edge at which the synchronised rise sets the bits
    @(posedge MCLK);
    wr(12'h044, 32'h7F0);
    rd(12'h03C, 32'h7F0);
  endtask
  task t_freeze;
    wr(12'h044, 32'h7F0);
    rd(12'h03C, '0);
    wr(12'h038, 32'h410);
    rd(12'h03C, 32'h410);
    @(posedge MCLK);
    CE <= 0;
    wr(12'h048, 32'h7F0);
    CE <= 1;
    rd(12'h048, '0);
  endtask
  initial begin
    repeat (3) @(posedge MCLK);
    RESET <= 0;
    t_id;
    t_irq;
    t_mask;
    t_race;
    t_freeze;
    end_of_test;
  end
  initial begin
    #50000;
    errors++;
    end_of_test;
  end
endmodule
`default_nettype wire

//--- verilog/uic_map.vh
`ifndef UIC_MAP_VH
`define UIC_MAP_VH
`define UIC_ADDR_W 12
`define UIC_OFS_RAW 12'h03C
`define UIC_OFS_MASKED 12'h040
`define UIC_OFS_CLEAR 12'h044
`define UIC_OFS_IDENT4 12'hFD0
`define UIC_OFS_SET 12'h038
`define UIC_OFS_MASK 12'h048
`define UIC_SRC_N 7
`define UIC_SRC_LO 4
`define UIC_SRC_HI 10
`define UIC_BIT_OVERRUN 10
`define UIC_BIT_BREAK 9
`define UIC_BIT_PARITY 8
`define UIC_BIT_FRAMING 7
`define UIC_BIT_RX_TIMEOUT 6
`define UIC_BIT_TX 5
`define UIC_BIT_RX 4
`define UIC_SRC_RESET 7'h00
`define UIC_DATA_ZERO 32'h0000_0000
`define UIC_IDENT4_VAL 8'h5A
`endif

//--- verilog/uic_srcbit.v
`timescale 1ns/100ps
`default_nettype none
// one sticky source bit: hardware set beats a software clear in the same cycle
module uic_srcbit (
  input wire clk,
  input wire rst,
  input wire ce,
  input wire set,
  input wire clr,
  output reg state_q
);
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= 1'b0;
    end else if (ce) begin
      if (set) begin
        state_q <= 1'b1;
      end else if (clr) begin
        state_q <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

//--- verilog/uic_top.v
// Summary of operation
// R1 - masked status register at 0x040 reads present masked state of sources
// R2 - writes to masked status register are ignored
// R3 - masked bits: overrun 10, break 9, parity 8, framing 7, timeout 6, tx 5, rx 4
// R4 - clear register at 0x044: writing one clears raw and masked status
// R5 - writing zero to a clear bit leaves that source untouched
// R6 - clear bits sit at the same positions as masked status bits
// R7 - reserved bits read as zero; software must not alter them
// R8 - read-only identity register at 0xFD0, byte in bits 7:0
// R9 - a raw status bit is kept per source before masking
// R10 - masked bit is raw AND mask enable; interrupt while any masked bit set
// R11 - masked status and clear bits are zero after reset
`timescale 1ns/100ps
`default_nettype none
`include "uic_map.vh"
module uic_top #(
  parameter [7:0] IDENT4 = `UIC_IDENT4_VAL
) (
  input wire MCLK,
  input wire RESET,
  input wire CE,
  input wire [`UIC_ADDR_W-1:0] ADDR,
  input wire [31:0] WDATA,
  input wire WR,
  input wire RD,
  input wire OVERRUN_EVT,
  input wire BREAK_EVT,
  input wire PARITY_EVT,
  input wire FRAMING_EVT,
  input wire RX_TIMEOUT_EVT,
  input wire TX_EVT,
  input wire RX_EVT,
  output reg [31:0] RDATA,
  output reg IRQ
);
  // identity value above is arbitrary

  // two stages settle the level; the third exists only for edge detection
  reg [`UIC_SRC_N-1:0] sync1_q;
  reg [`UIC_SRC_N-1:0] sync2_q;
  reg [`UIC_SRC_N-1:0] sync3_q;
  wire [`UIC_SRC_N-1:0] evt_in;
  wire [`UIC_SRC_N-1:0] evt_s;

  // per-source terms, spelled out so that each bit can be traced by name
  wire overrun_edge;
  wire break_edge;
  wire parity_edge;
  wire framing_edge;
  wire rx_timeout_edge;
  wire tx_edge;
  wire rx_edge;

  wire overrun_set;
  wire break_set;
  wire parity_set;
  wire framing_set;
  wire rx_timeout_set;
  wire tx_set;
  wire rx_set;

  wire overrun_clear;
  wire break_clear;
  wire parity_clear;
  wire framing_clear;
  wire rx_timeout_clear;
  wire tx_clear;
  wire rx_clear;

  wire overrun_raw;
  wire break_raw;
  wire parity_raw;
  wire framing_raw;
  wire rx_timeout_raw;
  wire tx_raw;
  wire rx_raw;

  wire overrun_en;
  wire break_en;
  wire parity_en;
  wire framing_en;
  wire rx_timeout_en;
  wire tx_en;
  wire rx_en;

  wire overrun_masked;
  wire break_masked;
  wire parity_masked;
  wire framing_masked;
  wire rx_timeout_masked;
  wire tx_masked;
  wire rx_masked;

  wire [`UIC_SRC_N-1:0] raw;
  wire [`UIC_SRC_N-1:0] masked;
  wire wr_clear;
  wire wr_set;
  wire wr_mask;
  reg [`UIC_SRC_N-1:0] mask_q;
  reg [31:0] rdata_d;
  reg irq_d;

  // address match, shared by every write decode
  function hit;
    input [`UIC_ADDR_W-1:0] a;
    input [`UIC_ADDR_W-1:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction

  function wbit;
    input [31:0] w;
    input integer pos;
    begin
      wbit = w[pos];
    end
  endfunction

  // event pins come from the serial core's own logic, possibly another clock
  assign evt_in = {
    OVERRUN_EVT,
    BREAK_EVT,
    PARITY_EVT,
    FRAMING_EVT,
    RX_TIMEOUT_EVT,
    TX_EVT,
    RX_EVT
  };

  always @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      sync1_q <= `UIC_SRC_RESET;
      sync2_q <= `UIC_SRC_RESET;
    end else if (CE) begin
      sync1_q <= evt_in;
      sync2_q <= sync1_q;
    end
  end

  // event pins idle low, so a zero reset value gives no false edge after reset
  always @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      sync3_q <= `UIC_SRC_RESET;
    end else if (CE) begin
      sync3_q <= sync2_q;
    end
  end

  // a level held high sets its bit once; software may clear it while it stays high
  assign evt_s = sync2_q & ~sync3_q;
  assign overrun_edge = evt_s[`UIC_BIT_OVERRUN - `UIC_SRC_LO];
  assign break_edge = evt_s[`UIC_BIT_BREAK - `UIC_SRC_LO];
  assign parity_edge = evt_s[`UIC_BIT_PARITY - `UIC_SRC_LO];
  assign framing_edge = evt_s[`UIC_BIT_FRAMING - `UIC_SRC_LO];
  assign rx_timeout_edge = evt_s[`UIC_BIT_RX_TIMEOUT - `UIC_SRC_LO];
  assign tx_edge = evt_s[`UIC_BIT_TX - `UIC_SRC_LO];
  assign rx_edge = evt_s[`UIC_BIT_RX - `UIC_SRC_LO];

  // writes to masked status or identity decode to nothing, so they change no state
  assign wr_clear = WR & hit(ADDR, `UIC_OFS_CLEAR); // R4
  assign wr_set = WR & hit(ADDR, `UIC_OFS_SET);
  assign wr_mask = WR & hit(ADDR, `UIC_OFS_MASK);

  // the set word is a test hook that raises a raw bit without the serial core
  assign overrun_set = overrun_edge | (wr_set & wbit(WDATA, `UIC_BIT_OVERRUN));
  assign break_set = break_edge | (wr_set & wbit(WDATA, `UIC_BIT_BREAK));
  assign parity_set = parity_edge | (wr_set & wbit(WDATA, `UIC_BIT_PARITY));
  assign framing_set = framing_edge | (wr_set & wbit(WDATA, `UIC_BIT_FRAMING));
  assign rx_timeout_set = rx_timeout_edge | (wr_set & wbit(WDATA, `UIC_BIT_RX_TIMEOUT));
  assign tx_set = tx_edge | (wr_set & wbit(WDATA, `UIC_BIT_TX));
  assign rx_set = rx_edge | (wr_set & wbit(WDATA, `UIC_BIT_RX));

  // a one clears its source, a zero leaves it alone; a set in the same cycle wins
  assign overrun_clear = wr_clear & wbit(WDATA, `UIC_BIT_OVERRUN); // R4 R5 R6
  assign break_clear = wr_clear & wbit(WDATA, `UIC_BIT_BREAK); // R4 R5 R6
  assign parity_clear = wr_clear & wbit(WDATA, `UIC_BIT_PARITY); // R4 R5 R6
  assign framing_clear = wr_clear & wbit(WDATA, `UIC_BIT_FRAMING); // R4 R5 R6
  assign rx_timeout_clear = wr_clear & wbit(WDATA, `UIC_BIT_RX_TIMEOUT); // R4 R5 R6
  assign tx_clear = wr_clear & wbit(WDATA, `UIC_BIT_TX); // R4 R5 R6
  assign rx_clear = wr_clear & wbit(WDATA, `UIC_BIT_RX); // R4 R5 R6

  // one sticky cell per source, listed from the top bit down
  uic_srcbit u_overrun (
    .clk(MCLK),
    .rst(RESET),
    .ce(CE),
    .set(overrun_set),
    .clr(overrun_clear),
    .state_q(overrun_raw)
  ); // R9 R11

  uic_srcbit u_break (
    .clk(MCLK),
    .rst(RESET),
    .ce(CE),
    .set(break_set),
    .clr(break_clear),
    .state_q(break_raw)
  ); // R9 R11

  uic_srcbit u_parity (
    .clk(MCLK),
    .rst(RESET),
    .ce(CE),
    .set(parity_set),
    .clr(parity_clear),
    .state_q(parity_raw)
  ); // R9 R11

  uic_srcbit u_framing (
    .clk(MCLK),
    .rst(RESET),
    .ce(CE),
    .set(framing_set),
    .clr(framing_clear),
    .state_q(framing_raw)
  ); // R9 R11

  uic_srcbit u_rx_timeout (
    .clk(MCLK),
    .rst(RESET),
    .ce(CE),
    .set(rx_timeout_set),
    .clr(rx_timeout_clear),
    .state_q(rx_timeout_raw)
  ); // R9 R11

  uic_srcbit u_tx (
    .clk(MCLK),
    .rst(RESET),
    .ce(CE),
    .set(tx_set),
    .clr(tx_clear),
    .state_q(tx_raw)
  ); // R9 R11

  uic_srcbit u_rx (
    .clk(MCLK),
    .rst(RESET),
    .ce(CE),
    .set(rx_set),
    .clr(rx_clear),
    .state_q(rx_raw)
  ); // R9 R11

  assign raw = {
    overrun_raw,
    break_raw,
    parity_raw,
    framing_raw,
    rx_timeout_raw,
    tx_raw,
    rx_raw
  };

  // mask enables, one per source
  assign overrun_en = mask_q[`UIC_BIT_OVERRUN - `UIC_SRC_LO];
  assign break_en = mask_q[`UIC_BIT_BREAK - `UIC_SRC_LO];
  assign parity_en = mask_q[`UIC_BIT_PARITY - `UIC_SRC_LO];
  assign framing_en = mask_q[`UIC_BIT_FRAMING - `UIC_SRC_LO];
  assign rx_timeout_en = mask_q[`UIC_BIT_RX_TIMEOUT - `UIC_SRC_LO];
  assign tx_en = mask_q[`UIC_BIT_TX - `UIC_SRC_LO];
  assign rx_en = mask_q[`UIC_BIT_RX - `UIC_SRC_LO];

  assign overrun_masked = overrun_raw & overrun_en; // R10
  assign break_masked = break_raw & break_en; // R10
  assign parity_masked = parity_raw & parity_en; // R10
  assign framing_masked = framing_raw & framing_en; // R10
  assign rx_timeout_masked = rx_timeout_raw & rx_timeout_en; // R10
  assign tx_masked = tx_raw & tx_en; // R10
  assign rx_masked = rx_raw & rx_en; // R10

  assign masked = {
    overrun_masked,
    break_masked,
    parity_masked,
    framing_masked,
    rx_timeout_masked,
    tx_masked,
    rx_masked
  };

  always @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      mask_q <= `UIC_SRC_RESET;
    end else if (CE) begin
      if (wr_mask) begin
        mask_q <= WDATA[`UIC_SRC_HI:`UIC_SRC_LO];
      end
    end
  end

  // reserved and unmapped bits read as zero, though software may not rely on it
  always @* begin
    rdata_d = `UIC_DATA_ZERO; // R7
    case (ADDR)
      `UIC_OFS_MASKED: begin
        rdata_d[`UIC_BIT_OVERRUN] = overrun_masked; // R1 R2 R3
        rdata_d[`UIC_BIT_BREAK] = break_masked; // R3
        rdata_d[`UIC_BIT_PARITY] = parity_masked; // R3
        rdata_d[`UIC_BIT_FRAMING] = framing_masked; // R3
        rdata_d[`UIC_BIT_RX_TIMEOUT] = rx_timeout_masked; // R3
        rdata_d[`UIC_BIT_TX] = tx_masked; // R3
        rdata_d[`UIC_BIT_RX] = rx_masked; // R3
      end
      `UIC_OFS_RAW: begin
        rdata_d[`UIC_BIT_OVERRUN] = overrun_raw; // R9
        rdata_d[`UIC_BIT_BREAK] = break_raw;
        rdata_d[`UIC_BIT_PARITY] = parity_raw;
        rdata_d[`UIC_BIT_FRAMING] = framing_raw;
        rdata_d[`UIC_BIT_RX_TIMEOUT] = rx_timeout_raw;
        rdata_d[`UIC_BIT_TX] = tx_raw;
        rdata_d[`UIC_BIT_RX] = rx_raw;
      end
      `UIC_OFS_MASK: begin
        rdata_d[`UIC_BIT_OVERRUN] = overrun_en;
        rdata_d[`UIC_BIT_BREAK] = break_en;
        rdata_d[`UIC_BIT_PARITY] = parity_en;
        rdata_d[`UIC_BIT_FRAMING] = framing_en;
        rdata_d[`UIC_BIT_RX_TIMEOUT] = rx_timeout_en;
        rdata_d[`UIC_BIT_TX] = tx_en;
        rdata_d[`UIC_BIT_RX] = rx_en;
      end
      `UIC_OFS_IDENT4: rdata_d = {24'h00_0000, IDENT4}; // R8
      default: rdata_d = `UIC_DATA_ZERO;
    endcase
  end

  always @* begin
    irq_d = |masked; // R10
  end

  always @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      RDATA <= `UIC_DATA_ZERO;
    end else if (CE) begin
      RDATA <= RD ? rdata_d : `UIC_DATA_ZERO;
    end
  end

  // flopped, so the level lags masked status by one cycle
  always @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      IRQ <= 1'b0;
    end else if (CE) begin
      IRQ <= irq_d; // R10
    end
  end
endmodule
`default_nettype wire
